// [hdl/amx_pkg.sv]
// constants and types shared by the input multiplexer configuration decoder
`default_nettype none

package amx_pkg;

	// =========================================================
	// configuration word layout
	localparam int unsigned CFG_W       = 14;
	localparam int unsigned CFG_INCC_HI = 12;
	localparam int unsigned CFG_INCC_LO = 10;
	localparam int unsigned CFG_CHAN_HI = 9;
	localparam int unsigned CFG_CHAN_LO = 7;
	localparam int unsigned CFG_BW_BIT  = 6;
	localparam logic [13:0] CFG_RST     = 14'h1C00;

	// =========================================================
	// input configuration codes
	localparam logic [2:0] INCC_SE      = 3'h7;
	localparam logic [2:0] INCC_COM_BIP = 3'h2;
	localparam logic [2:0] INCC_COM_UNI = 3'h6;
	localparam logic [1:0] INCC_PR_BIP  = 2'h0;
	localparam logic [1:0] INCC_PR_UNI  = 2'h2;

	// =========================================================
	// register map
	localparam int unsigned ADDR_W      = 12;
	localparam logic [11:0] REG_CFG     = 12'h000;
	localparam logic [11:0] REG_STATUS  = 12'h004;
	localparam logic [11:0] REG_RESULT  = 12'h008;

	// status fields
	localparam int unsigned ST_CONV     = 0;
	localparam int unsigned ST_MODE_LO  = 1;
	localparam int unsigned ST_BIP      = 4;
	localparam int unsigned ST_QUARTER  = 5;
	localparam int unsigned ST_POS_LO   = 6;
	localparam int unsigned ST_NEG_LO   = 9;
	localparam int unsigned ST_NEG_COM  = 12;
	localparam int unsigned ST_NEG_GND  = 13;
	localparam int unsigned ST_PENDING  = 14;
	localparam int unsigned ST_NEW      = 15;

	// result fields
	localparam int unsigned RES_W       = 14;
	localparam int unsigned RES_NEW     = 16;
	localparam int unsigned RES_BIP     = 17;

	// =========================================================
	// types
	typedef enum logic [2:0] {
		MODE_NONE,
		MODE_SE,
		MODE_COM_BIP,
		MODE_COM_UNI,
		MODE_PR_BIP,
		MODE_PR_UNI
	} amx_mode_e;

	typedef enum logic {
		PH_ACQ,
		PH_CONV
	} amx_phase_e;

endpackage

`default_nettype wire

// [hdl/amx_sync.sv]
// two-stage synchroniser with rising-edge detector behind it
`default_nettype none

module amx_sync
(
	input  wire logic clk_sys_i,
	input  wire logic rst_n_i,
	input  wire logic async_i,
	output logic      level_o,
	output logic      rise_o
);

	logic meta_q;
	logic sync_q;
	logic last_q;

	// =========================================================
	// crossing, first stage read only by the second
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end
		else
		begin
			meta_q <= async_i;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign level_o = sync_q;
	assign rise_o  = sync_q & ~last_q;

endmodule

`default_nettype wire

// [hdl/amx_decode.sv]
// maps a decoded input scheme and channel onto multiplexer switch vectors
`default_nettype none

module amx_decode
(
	input  wire amx_pkg::amx_mode_e mode_i,
	input  wire logic [2:0]         chan_i,
	input  wire logic               seq_i,
	output logic [7:0]              pos_o,
	output logic [7:0]              neg_o,
	output logic [2:0]              pos_idx_o,
	output logic [2:0]              neg_idx_o,
	output logic                    neg_com_o,
	output logic                    neg_gnd_o,
	output logic                    bip_o
);

	logic paired;
	logic pos_on;

	assign paired = (mode_i == amx_pkg::MODE_PR_BIP) || (mode_i == amx_pkg::MODE_PR_UNI);
	assign pos_on = (mode_i != amx_pkg::MODE_NONE);

	// =========================================================
	// positive member of a pair
	always_comb
	begin
		pos_idx_o = chan_i;
		if (paired && seq_i)
			pos_idx_o = {chan_i[2:1], 1'b0};
		neg_idx_o = {pos_idx_o[2:1], ~pos_idx_o[0]};
	end

	// =========================================================
	// one-hot switch vectors
	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : g_sw
			assign pos_o[g] = pos_on && (pos_idx_o == 3'(g));
			assign neg_o[g] = paired && (neg_idx_o == 3'(g));
		end
	endgenerate

	// =========================================================
	// negative reference and polarity
	always_comb
	begin
		neg_com_o = 1'b0;
		neg_gnd_o = 1'b0;
		bip_o     = 1'b0;
		case (mode_i)
			amx_pkg::MODE_SE:
			begin
				neg_gnd_o = 1'b1;
			end
			amx_pkg::MODE_COM_BIP:
			begin
				neg_com_o = 1'b1;
				bip_o     = 1'b1;
			end
			amx_pkg::MODE_COM_UNI:
			begin
				neg_com_o = 1'b1;
			end
			amx_pkg::MODE_PR_BIP:
			begin
				bip_o = 1'b1;
			end
			amx_pkg::MODE_PR_UNI:
			begin
				bip_o = 1'b0;
			end
			default:
			begin
				bip_o = 1'b0;
			end
		endcase
	end

endmodule

`default_nettype wire

// [hdl/amx_top.sv]
// input multiplexer configuration decoder with apb register access
//
// The address map and register access over APB are this design's own decisions.
`default_nettype none

module amx_top
(
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic             pready_o,
	output logic [31:0]      prdata_o,
	output logic             pslverr_o,
	// conversion timing
	input  wire logic        convert_start_i,
	input  wire logic        conv_done_i,
	input  wire logic [13:0] conv_raw_i,
	// channel sequencer
	input  wire logic        seq_active_i,
	input  wire logic [2:0]  seq_chan_i,
	// analog switch controls
	output logic             acquire_o,
	output logic [7:0]       pos_sw_o,
	output logic [7:0]       neg_sw_o,
	output logic             neg_com_o,
	output logic             neg_gnd_o,
	output logic             filter_bandwidth_select_o,
	// result path
	output logic [13:0]      result_o,
	output logic             result_valid_o,
	output logic             twos_comp_o
);

	// =========================================================
	// declarations
	amx_pkg::amx_phase_e phase_q;
	amx_pkg::amx_mode_e  act_mode_q;
	amx_pkg::amx_mode_e  pend_mode;
	logic [13:0]         cfg_q;
	logic [13:0]         act_cfg_q;
	logic                act_seq_q;
	logic [2:0]          act_chan_q;
	logic                cnv_level;
	logic                cnv_rise;
	logic                start_conv;
	logic                end_conv;
	logic [7:0]          dec_pos;
	logic [7:0]          dec_neg;
	logic [2:0]          dec_pos_idx;
	logic [2:0]          dec_neg_idx;
	logic                dec_com;
	logic                dec_gnd;
	logic                dec_bip;
	logic [2:0]          pos_idx_q;
	logic [2:0]          neg_idx_q;
	logic                conv_bip_q;
	logic                res_new_q;
	logic                apb_acc;
	logic                apb_wr;
	logic                apb_rd;
	logic                hit;
	logic [31:0]         rd_word;

	// =========================================================
	// decoding of the input configuration field
	function automatic amx_pkg::amx_mode_e incc_mode(input logic [13:0] cfg);
		logic [2:0] f;
		f = cfg[amx_pkg::CFG_INCC_HI:amx_pkg::CFG_INCC_LO];
		if (f == amx_pkg::INCC_SE)
			incc_mode = amx_pkg::MODE_SE;
		else if (f == amx_pkg::INCC_COM_BIP)
			incc_mode = amx_pkg::MODE_COM_BIP;
		else if (f == amx_pkg::INCC_COM_UNI)
			incc_mode = amx_pkg::MODE_COM_UNI;
		else if (f[2:1] == amx_pkg::INCC_PR_BIP)
			incc_mode = amx_pkg::MODE_PR_BIP;
		else if (f[2:1] == amx_pkg::INCC_PR_UNI)
			incc_mode = amx_pkg::MODE_PR_UNI;
		else
			incc_mode = amx_pkg::MODE_NONE;
	endfunction

	assign pend_mode = incc_mode(cfg_q);

	// =========================================================
	// convert start pin crossing
	amx_sync u_cnv_sync
	(
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.async_i   (convert_start_i),
		.level_o   (cnv_level),
		.rise_o    (cnv_rise)
	);

	// an edge during a conversion is dropped; the level alone starts nothing
	assign start_conv = (phase_q == amx_pkg::PH_ACQ) && cnv_rise && cnv_level;
	assign end_conv   = (phase_q == amx_pkg::PH_CONV) && conv_done_i;

	// =========================================================
	// acquisition and conversion phases
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			phase_q <= amx_pkg::PH_ACQ;
		else
		begin
			case (phase_q)
				amx_pkg::PH_ACQ:
				begin
					if (start_conv)
						phase_q <= amx_pkg::PH_CONV;
				end
				amx_pkg::PH_CONV:
				begin
					if (end_conv)
						phase_q <= amx_pkg::PH_ACQ;
				end
				default:
				begin
					phase_q <= amx_pkg::PH_ACQ;
				end
			endcase
		end
	end

	// =========================================================
	// configuration word written by software
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			cfg_q <= amx_pkg::CFG_RST;
		else if (apb_wr && (paddr_i == amx_pkg::REG_CFG))
			cfg_q <= pwdata_i[13:0];
	end

	// =========================================================
	// active configuration, taken over only at acquisition start
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			act_cfg_q  <= amx_pkg::CFG_RST;
			act_mode_q <= amx_pkg::MODE_SE;
			act_seq_q  <= 1'b0;
			act_chan_q <= 3'h0;
		end
		else if (end_conv)
		begin
			act_cfg_q  <= cfg_q;
			act_mode_q <= pend_mode;
			act_seq_q  <= seq_active_i;
			act_chan_q <= seq_active_i ? seq_chan_i : cfg_q[amx_pkg::CFG_CHAN_HI:amx_pkg::CFG_CHAN_LO];
		end
	end

	// =========================================================
	// switch pattern for the active configuration
	amx_decode u_decode
	(
		.mode_i    (act_mode_q),
		.chan_i    (act_chan_q),
		.seq_i     (act_seq_q),
		.pos_o     (dec_pos),
		.neg_o     (dec_neg),
		.pos_idx_o (dec_pos_idx),
		.neg_idx_o (dec_neg_idx),
		.neg_com_o (dec_com),
		.neg_gnd_o (dec_gnd),
		.bip_o     (dec_bip)
	);

	// =========================================================
	// analog switch drive
	// switch vectors hold during conversion, since the active configuration only changes at its end; acquire_o drops
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			acquire_o <= 1'b0;
			pos_sw_o  <= 8'h00;
			neg_sw_o  <= 8'h00;
			neg_com_o <= 1'b0;
			neg_gnd_o <= 1'b0;
			pos_idx_q <= 3'h0;
			neg_idx_q <= 3'h0;
		end
		else
		begin
			acquire_o <= (phase_q == amx_pkg::PH_ACQ) && !start_conv;
			pos_sw_o  <= dec_pos;
			neg_sw_o  <= dec_neg;
			neg_com_o <= dec_com;
			neg_gnd_o <= dec_gnd;
			pos_idx_q <= dec_pos_idx;
			neg_idx_q <= dec_neg_idx;
		end
	end

	// =========================================================
	// input filter bandwidth
	// the required slower rate is the host's duty; nothing here enforces it
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			filter_bandwidth_select_o <= 1'b0;
		else
			filter_bandwidth_select_o <= act_cfg_q[amx_pkg::CFG_BW_BIT];
	end

	// =========================================================
	// result coding, polarity frozen with the conversion
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			conv_bip_q <= 1'b0;
		else if (start_conv)
			conv_bip_q <= dec_bip;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			result_o       <= 14'h0000;
			result_valid_o <= 1'b0;
			twos_comp_o    <= 1'b0;
		end
		else
		begin
			result_valid_o <= end_conv;
			if (end_conv)
			begin
				twos_comp_o <= conv_bip_q;
				if (conv_bip_q)
					result_o <= {~conv_raw_i[13], conv_raw_i[12:0]};
				else
					result_o <= conv_raw_i;
			end
		end
	end

	// =========================================================
	// apb slave, one wait state
	assign apb_acc = psel_i && penable_i;
	assign apb_wr  = apb_acc && pready_o && pwrite_i;
	assign apb_rd  = apb_acc && pready_o && !pwrite_i;
	assign hit     = (paddr_i == amx_pkg::REG_CFG) || (paddr_i == amx_pkg::REG_STATUS) ||
	                 (paddr_i == amx_pkg::REG_RESULT);

	// new-result flag: a set wins over a read clear
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			res_new_q <= 1'b0;
		else if (end_conv)
			res_new_q <= 1'b1;
		else if (apb_rd && (paddr_i == amx_pkg::REG_RESULT))
			res_new_q <= 1'b0;
	end

	always_comb
	begin
		rd_word = 32'h00000000;
		case (paddr_i)
			amx_pkg::REG_CFG:
			begin
				rd_word[13:0] = cfg_q;
			end
			amx_pkg::REG_STATUS:
			begin
				rd_word[amx_pkg::ST_CONV]                          = (phase_q == amx_pkg::PH_CONV);
				rd_word[amx_pkg::ST_MODE_LO+2:amx_pkg::ST_MODE_LO] = act_mode_q;
				rd_word[amx_pkg::ST_BIP]                           = dec_bip;
				rd_word[amx_pkg::ST_QUARTER]                       = filter_bandwidth_select_o;
				rd_word[amx_pkg::ST_POS_LO+2:amx_pkg::ST_POS_LO]   = pos_idx_q;
				rd_word[amx_pkg::ST_NEG_LO+2:amx_pkg::ST_NEG_LO]   = neg_idx_q;
				rd_word[amx_pkg::ST_NEG_COM]                       = neg_com_o;
				rd_word[amx_pkg::ST_NEG_GND]                       = neg_gnd_o;
				rd_word[amx_pkg::ST_PENDING]                       = (cfg_q != act_cfg_q);
				rd_word[amx_pkg::ST_NEW]                           = res_new_q;
			end
			amx_pkg::REG_RESULT:
			begin
				rd_word[amx_pkg::RES_W-1:0] = result_o;
				rd_word[amx_pkg::RES_NEW]   = res_new_q;
				rd_word[amx_pkg::RES_BIP]   = twos_comp_o;
			end
			default:
			begin
				rd_word = 32'h00000000;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			pready_o  <= 1'b0;
			prdata_o  <= 32'h00000000;
			pslverr_o <= 1'b0;
		end
		else
		begin
			pready_o  <= apb_acc && !pready_o;
			pslverr_o <= apb_acc && !pready_o && !hit;
			if (apb_acc && !pready_o && !pwrite_i)
				prdata_o <= rd_word;
			else
				prdata_o <= 32'h00000000;
		end
	end

endmodule

`default_nettype wire

// [dv/amx_top_chk.sv]
// port checker for the input multiplexer configuration decoder
`default_nettype none

module amx_top_chk
(
	input wire logic        clk_sys_i,
	input wire logic        rst_n_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pready_o,
	input wire logic [31:0] prdata_o,
	input wire logic        pslverr_o,
	input wire logic        convert_start_i,
	input wire logic        conv_done_i,
	input wire logic [13:0] conv_raw_i,
	input wire logic        acquire_o,
	input wire logic [7:0]  pos_sw_o,
	input wire logic [7:0]  neg_sw_o,
	input wire logic        neg_com_o,
	input wire logic        neg_gnd_o,
	input wire logic [13:0] result_o,
	input wire logic        result_valid_o,
	input wire logic        twos_comp_o
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	// =========================================================
	// register bus
	chk_pready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o) else $error("late bus answer");
	chk_pready_pulse: assert property (pready_o |=> !pready_o) else $error("bus answer too long");
	chk_slverr_with: assert property (pslverr_o |-> pready_o) else $error("error without answer");
	chk_prdata_idle: assert property (!pready_o |-> prdata_o == 32'h0) else $error("read data outside answer");

	// =========================================================
	// switch vectors
	chk_se_ground: assert property (neg_gnd_o |-> neg_sw_o == 8'h00 && !neg_com_o && $onehot(pos_sw_o))
		else $error("bad single-ended switches");
	chk_com_single: assert property (neg_com_o |-> neg_sw_o == 8'h00 && !neg_gnd_o && $onehot(pos_sw_o))
		else $error("bad common switches");
	chk_pair_adjacent: assert property (neg_sw_o != 8'h00 |-> $onehot(neg_sw_o) &&
		(((pos_sw_o & 8'h55) != 8'h00) ? neg_sw_o == 8'(pos_sw_o << 1) : neg_sw_o == (pos_sw_o >> 1)))
		else $error("pair not adjacent");
	chk_switch_hold: assert property (!acquire_o ##1 !acquire_o |-> $stable(pos_sw_o) && $stable(neg_sw_o))
		else $error("switches moved in conversion");

	// =========================================================
	// conversion
	chk_start_ack: assert property ($rose(convert_start_i) && acquire_o |-> ##[2:6] !acquire_o)
		else $error("start not taken");
	chk_done_result: assert property (conv_done_i && !acquire_o && !result_valid_o |=> result_valid_o)
		else $error("no result after done");
	chk_valid_acq: assert property (result_valid_o |=> !result_valid_o && acquire_o)
		else $error("no return to acquisition");
	chk_result_fmt: assert property (result_valid_o |-> result_o == (twos_comp_o ?
		{~$past(conv_raw_i[13]), $past(conv_raw_i[12:0])} : $past(conv_raw_i))) else $error("bad result code");

	cov_bipolar: cover property (result_valid_o && twos_comp_o);
	cov_unipolar: cover property (result_valid_o && !twos_comp_o);
	cov_pair: cover property (neg_sw_o != 8'h00 && acquire_o);
	cov_slverr: cover property (pslverr_o);
endmodule

`default_nettype wire

// [dv/amx_conv_model.sv]
// converter core and host pacing model on the far side
`default_nettype none

module amx_conv_model
(
	input  wire logic        clk_i,
	input  wire logic        req_i,
	input  wire logic        acquire_i,
	input  wire logic        bw_i,
	input  wire logic [13:0] raw_i,
	input  wire logic [3:0]  dly_i,
	output logic             convert_start_o,
	output logic             conv_done_o,
	output logic [13:0]      conv_raw_o
);
	timeunit 1ns;
	timeprecision 1ps;

	int k;

	initial
	begin
		convert_start_o = 1'b0;
		conv_done_o = 1'b0;
		conv_raw_o = 14'h2AAA;
		forever
		begin
			@(posedge clk_i);
			if (req_i === 1'b1)
			begin
				repeat (bw_i ? 12 : 3) @(posedge clk_i);
				convert_start_o <= 1'b1;
				k = 0;
				while (acquire_i !== 1'b0 && k < 20)
				begin
					@(posedge clk_i);
					k++;
				end
				repeat (dly_i) @(posedge clk_i);
				conv_done_o <= 1'b1;
				conv_raw_o <= raw_i;
				@(posedge clk_i);
				conv_done_o <= 1'b0;
				// stale code inverted so a late sample shows up
				conv_raw_o <= ~raw_i;
				convert_start_o <= 1'b0;
				wait (req_i !== 1'b1);
			end
		end
	end
endmodule

`default_nettype wire

// [dv/amx_top_tb.sv]
// self-checking bench for the input multiplexer configuration decoder
`default_nettype none

module amx_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_sys_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0;
	logic        seq_active_i = 1'b0;
	logic [2:0]  seq_chan_i = 3'h0;
	logic        convert_start_i, conv_done_i, pready_o, pslverr_o, acquire_o, neg_com_o, neg_gnd_o;
	logic        filter_bandwidth_select_o, result_valid_o, twos_comp_o;
	logic [13:0] conv_raw_i, result_o;
	logic [31:0] prdata_o;
	logic [7:0]  pos_sw_o, neg_sw_o;
	logic        req = 1'b0;
	logic [13:0] mraw = 14'h0;
	logic [3:0]  dly = 4'h0;
	logic [15:0] lf = 16'h6399;
	logic [2:0]  codes [8] = '{3'h7, 3'h2, 3'h6, 3'h0, 3'h1, 3'h4, 3'h5, 3'h3};
	int          failures = 0;
	int          n_checks = 0;

	always #2 clk_sys_i = ~clk_sys_i;

	amx_top dut_u (.clk_sys_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o,
		.prdata_o, .pslverr_o, .convert_start_i, .conv_done_i, .conv_raw_i, .seq_active_i, .seq_chan_i,
		.acquire_o, .pos_sw_o, .neg_sw_o, .neg_com_o, .neg_gnd_o, .filter_bandwidth_select_o, .result_o,
		.result_valid_o, .twos_comp_o);

	amx_conv_model cm_u (.clk_i(clk_sys_i), .req_i(req), .acquire_i(acquire_o),
		.bw_i(filter_bandwidth_select_o), .raw_i(mraw), .dly_i(dly), .convert_start_o(convert_start_i),
		.conv_done_o(conv_done_i), .conv_raw_o(conv_raw_i));

	// =========================================================
	// helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want)
		begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, seen, want);
		end
	endtask

	task automatic tally_and_finish;
		if (failures == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// bus master holds the request until pready is sampled
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int k;
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk_sys_i);
			k++;
		end
		while (pready_o !== 1'b1 && k < 50);
		if (k >= 50)
			failures++;
		r = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		// idle edge so a following call never reassigns psel in the same step
		@(posedge clk_sys_i);
	endtask

	task automatic wait_hi(ref logic s);
		int k;
		k = 0;
		do
		begin
			@(posedge clk_sys_i);
			k++;
		end
		while (s !== 1'b1 && k < 100);
		if (k >= 100)
			failures++;
	endtask

	// expected {bipolar, bw, com, gnd, neg, pos}
	function automatic logic [19:0] exp_sw(input logic [13:0] c, input logic sa, input logic [2:0] sc);
		logic [2:0] m;
		logic [2:0] ch;
		logic [7:0] p;
		logic [7:0] n;
		logic [1:0] rf;
		logic       bip;
		m = c[12:10];
		ch = sa ? sc : c[9:7];
		p = 8'h00;
		n = 8'h00;
		rf = 2'h0;
		bip = 1'b0;
		if (m == 3'h7)
		begin
			p = 8'h01 << ch;
			rf = 2'h1;
		end
		else if (m[1:0] == 2'h2)
		begin
			p = 8'h01 << ch;
			rf = 2'h2;
			bip = ~m[2];
		end
		else if (!m[1])
		begin
			ch[0] = ch[0] & ~sa;
			p = 8'h01 << ch;
			n = 8'h01 << (ch ^ 3'h1);
			bip = ~m[2];
		end
		return {bip, c[6], rf, n, p};
	endfunction

	task automatic sw_check(input logic [13:0] c, input logic sa, input logic [2:0] sc);
		logic [19:0] x;
		x = exp_sw(c, sa, sc);
		check(32'({filter_bandwidth_select_o, neg_com_o, neg_gnd_o, neg_sw_o, pos_sw_o}), 32'(x[18:0]));
	endtask

	// =========================================================
	// sequence
	initial
	begin
		logic [31:0] r;
		logic        e;
		logic [13:0] cfg;
		logic [13:0] act;
		logic        asa;
		logic [2:0]  asc;
		logic [19:0] x;
		logic [2:0]  ch;
		logic [13:0] er;
		repeat (16) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		act = amx_pkg::CFG_RST;
		asa = 1'b0;
		asc = 3'h0;
		sw_check(act, asa, asc);
		apb(1'b0, amx_pkg::REG_CFG, 32'h0, r, e);
		check(r, 32'(amx_pkg::CFG_RST));
		apb(1'b1, 12'hFFC, 32'h1234, r, e);
		check({31'h0, e}, 32'h1);
		for (int i = 0; i < 14; i++)
		begin
			lf = lfsr_next(lf);
			ch = (i == 3) ? 3'h0 : (i == 6) ? 3'h5 : lf[2:0];
			cfg = {1'b0, codes[i % 8], ch, lf[3], 6'h00};
			apb(1'b1, amx_pkg::REG_CFG, 32'(cfg), r, e);
			apb(1'b0, amx_pkg::REG_CFG, 32'h0, r, e);
			check(r, 32'(cfg));
			apb(1'b0, amx_pkg::REG_STATUS, 32'h0, r, e);
			check(32'({r[14], r[5], r[0]}), 32'({cfg != act, act[6], 1'b0}));
			sw_check(act, asa, asc);
			seq_active_i <= (i >= 8);
			seq_chan_i <= lf[6:4];
			mraw <= lf[15:2];
			dly <= lf[12:9];
			req <= 1'b1;
			wait_hi(result_valid_o);
			req <= 1'b0;
			x = exp_sw(act, asa, asc);
			check({31'h0, twos_comp_o}, {31'h0, x[19]});
			er = x[19] ? {~mraw[13], mraw[12:0]} : mraw;
			check(32'(result_o), 32'(er));
			act = cfg;
			asa = seq_active_i;
			asc = seq_chan_i;
			wait_hi(acquire_o);
			sw_check(act, asa, asc);
			apb(1'b0, amx_pkg::REG_RESULT, 32'h0, r, e);
			check(r, 32'({x[19], 1'b1, 2'h0, er}));
			apb(1'b0, amx_pkg::REG_RESULT, 32'h0, r, e);
			check(r, 32'({x[19], 1'b0, 2'h0, er}));
		end
		tally_and_finish();
	end

	initial
	begin
		#20000;
		failures++;
		tally_and_finish();
	end
endmodule

bind amx_top amx_top_chk chk_u (.clk_sys_i, .rst_n_i, .psel_i, .penable_i, .pready_o, .prdata_o, .pslverr_o,
	.convert_start_i, .conv_done_i, .conv_raw_i, .acquire_o, .pos_sw_o, .neg_sw_o, .neg_com_o, .neg_gnd_o,
	.result_o, .result_valid_o, .twos_comp_o);

`default_nettype wire
